// ==== sbpcd_defs.vh ====
// Purpose: constants for the state base pointer command decoder
// Assumes: 32-bit command dwords, AXI4-Lite register window
// Notes: header field positions, codes, register offsets and reset values
`ifndef SBPCD_DEFS_VH
`define SBPCD_DEFS_VH

// header dword fields
`define SBPCD_TYPE_HI        31
`define SBPCD_TYPE_LO        29
`define SBPCD_SUBTYPE_HI     28
`define SBPCD_SUBTYPE_LO     27
`define SBPCD_OPC_HI         26
`define SBPCD_OPC_LO         24
`define SBPCD_SUBOPC_HI      23
`define SBPCD_SUBOPC_LO      16
`define SBPCD_HRSV_HI        15
`define SBPCD_HRSV_LO        8
`define SBPCD_LEN_HI         7
`define SBPCD_LEN_LO         0

// header codes
`define SBPCD_GRAPHICS_PIPE_CMD_TYPE 3'h3
`define SBPCD_PIPE_COMMON_SUBTYPE    2'h0
`define SBPCD_UNPIPELINED_OPCODE     3'h1
`define SBPCD_BASE_PTR_SUBOPC        8'h01
`define SBPCD_LEN_DEFAULT            8'h04
`define SBPCD_LEN_BIAS               9'h002

// address dword fields
`define SBPCD_BASE_HI        31
`define SBPCD_BASE_LO        12
`define SBPCD_ARSV_HI        11
`define SBPCD_ARSV_LO        1
`define SBPCD_MOD_EN_BIT     0

// dword indices inside the command
`define SBPCD_DW_GEN         9'h001
`define SBPCD_DW_SURF        9'h002
`define SBPCD_DW_IND         9'h003

// register byte offsets
`define SBPCD_REG_CTRL       8'h00
`define SBPCD_REG_STATUS     8'h04
`define SBPCD_REG_GEN_BASE   8'h08
`define SBPCD_REG_SURF_BASE  8'h0C
`define SBPCD_REG_IND_BASE   8'h10
`define SBPCD_REG_CMD_COUNT  8'h14

// control and status bits
`define SBPCD_CTRL_EN_BIT    0
`define SBPCD_CTRL_RESET     1'b1
`define SBPCD_ST_BUSY_BIT    0
`define SBPCD_ST_FLUSH_BIT   1
`define SBPCD_ST_RSV_BIT     2
`define SBPCD_ST_TRUNC_BIT   3

// bus responses
`define SBPCD_RESP_OKAY      2'h0
`define SBPCD_RESP_DECERR    2'h3

`endif

// ==== sbpcd_hdr_match.v ====
// Purpose: recognise the base pointer command header
// Assumes: dword presented is a header dword
// Notes: purely combinational, read by the decoder state machine
`timescale 1ns/100ps
`include "sbpcd_defs.vh"

module sbpcd_hdr_match (
    input  wire [31:0] hdr,       // candidate header dword
    output wire        is_match,  // header names this command
    output wire [8:0]  total_len, // whole command length in dwords
    output wire        rsv_dirty  // must_be_zero bits were not zero
);
    // type and subtype select the common pipe class
    wire cls_ok = (hdr[`SBPCD_TYPE_HI:`SBPCD_TYPE_LO] == `SBPCD_GRAPHICS_PIPE_CMD_TYPE) &&
                  (hdr[`SBPCD_SUBTYPE_HI:`SBPCD_SUBTYPE_LO] == `SBPCD_PIPE_COMMON_SUBTYPE);
    // opcode and sub-opcode pick this command alone
    wire opc_ok = (hdr[`SBPCD_OPC_HI:`SBPCD_OPC_LO] == `SBPCD_UNPIPELINED_OPCODE) &&
                  (hdr[`SBPCD_SUBOPC_HI:`SBPCD_SUBOPC_LO] == `SBPCD_BASE_PTR_SUBOPC);

    assign is_match  = cls_ok && opc_ok;
    // length field counts dwords minus the bias
    assign total_len = {1'b0, hdr[`SBPCD_LEN_HI:`SBPCD_LEN_LO]} + `SBPCD_LEN_BIAS;
    // reserved header bits are only reported, never acted on
    assign rsv_dirty = |hdr[`SBPCD_HRSV_HI:`SBPCD_HRSV_LO];
endmodule // sbpcd_hdr_match

// ==== sbpcd_flush_ctl.v ====
// Purpose: hold a pipeline flush request until the pipe reports drained
// Assumes: flush_done is a one-cycle pulse from the pipeline
// Notes: done is a one-cycle pulse the edge after flush_done is seen
`timescale 1ns/100ps

module sbpcd_flush_ctl (
    input  wire aclk,       // engine clock
    input  wire aresetn,    // synchronous reset, active low
    input  wire start,      // pulse: begin a flush
    input  wire flush_done, // pulse: pipeline drained
    output reg  flush_req_q,// level: flush requested
    output reg  done_q      // pulse: flush finished
);
    // request stays up until the drain is acknowledged
    always @(posedge aclk) begin
        if (!aresetn) begin
            flush_req_q <= 1'b0;
            done_q      <= 1'b0;
        end else begin
            done_q <= flush_req_q && flush_done;
            if (start) begin
                flush_req_q <= 1'b1;
            end else if (flush_done) begin
                flush_req_q <= 1'b0;
            end
        end
    end
endmodule // sbpcd_flush_ctl

// ==== sbpcd_top.v ====
// Purpose: decode the state base pointer command and hold the engine bases
// Assumes: streamer marks each header dword with cmd_first
// Notes: bases change only after the flush finishes; registers on AXI4-Lite
//
// How it works
// - header type 3, subtype 0 required
// - opcode 1, sub-opcode 01h identify command
// - length field plus two ends command
// - dword 1 bits 31:12 general state base
// - dword 2 bits 31:12 surface state base
// - dword 3 bits 31:12 indirect object base
// - bit 0 gates each base update
// - enable 0 discards, 1 loads address
// - loaded bases drive all later accesses
// - command forces full flush before applying
// - zero base means offsets are absolute
//
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/100ps
`include "sbpcd_defs.vh"

module sbpcd_top (
    input  wire        aclk,          // engine clock, 250 MHz
    input  wire        aresetn,       // synchronous reset, active low
    // command stream from the streamer
    input  wire        cmd_valid,     // dword offered
    input  wire [31:0] cmd_data,      // command dword
    input  wire        cmd_first,     // dword is a header
    output reg         cmd_ready_q,   // decoder takes dword

    // pipeline flush handshake
    output wire        flush_req_q,   // flush requested, from flop
    input  wire        flush_done,    // pulse: pipe drained

    // bases seen by the engine's memory paths
    output reg  [19:0] gen_base_q,    // general state base [31:12]
    output reg  [19:0] surf_base_q,   // surface state base [31:12]
    output reg  [19:0] ind_base_q,    // indirect object base [31:12]
    output reg         apply_q,       // pulse: new bases in effect

    // AXI4-Lite slave
    input  wire [7:0]  s_awaddr,
    input  wire        s_awvalid,
    output reg         s_awready,
    input  wire [31:0] s_wdata,
    input  wire [3:0]  s_wstrb,
    input  wire        s_wvalid,
    output reg         s_wready,
    output reg  [1:0]  s_bresp,
    output reg         s_bvalid,
    input  wire        s_bready,
    input  wire [7:0]  s_araddr,
    input  wire        s_arvalid,
    output reg         s_arready,
    output reg  [31:0] s_rdata,
    output reg  [1:0]  s_rresp,
    output reg         s_rvalid,
    input  wire        s_rready
);
    // decoder states
    localparam [2:0] ST_IDLE  = 3'h0; // waiting for a header
    localparam [2:0] ST_BODY  = 3'h1; // taking address dwords
    localparam [2:0] ST_FLUSH = 3'h2; // flush requested
    localparam [2:0] ST_WAIT  = 3'h3; // waiting for drain
    localparam [2:0] ST_SKIP  = 3'h4; // draining a foreign command

    reg  [2:0]  state_q, state_d;       // decoder state
    reg  [8:0]  idx_q, idx_d;           // dword index in command
    reg  [8:0]  len_q, len_d;           // total dwords in command
    reg  [19:0] gen_pend_q;             // staged general base
    reg  [19:0] surf_pend_q;            // staged surface base
    reg  [19:0] ind_pend_q;             // staged indirect base
    reg  [2:0]  pend_en_q;              // staged modify enables

    reg         ctrl_en_q;              // software decode enable
    reg         rsv_flag_q;             // sticky: reserved bits dirty
    reg         trunc_flag_q;           // sticky: command cut short
    reg  [31:0] cmd_count_q;            // commands applied

    reg         aw_held_q, w_held_q;    // write halves captured
    reg  [7:0]  aw_addr_q;              // captured write address
    reg  [31:0] w_data_q;               // captured write data
    reg  [3:0]  w_strb_q;               // captured byte enables

    wire        hdr_hit;                // header is this command
    wire [8:0]  hdr_len;                // header total length
    wire        hdr_rsv;                // header reserved bits set
    wire        flush_fin;              // flush acknowledged pulse

    wire        take = cmd_valid && cmd_ready_q;
    wire        flush_go = (state_q == ST_FLUSH);
    // address dwords with reserved bits set
    wire        addr_rsv = |cmd_data[`SBPCD_ARSV_HI:`SBPCD_ARSV_LO];
    wire        mod_en = cmd_data[`SBPCD_MOD_EN_BIT];

    // true when a register offset is one this block maps
    function mapped;
        input [7:0] a;
        begin
            mapped = (a == `SBPCD_REG_CTRL) || (a == `SBPCD_REG_STATUS) ||
                     (a == `SBPCD_REG_GEN_BASE) || (a == `SBPCD_REG_SURF_BASE) ||
                     (a == `SBPCD_REG_IND_BASE) || (a == `SBPCD_REG_CMD_COUNT);
        end
    endfunction

    // header recognition
    sbpcd_hdr_match u_hdr (
        .hdr       (cmd_data),
        .is_match  (hdr_hit),
        .total_len (hdr_len),
        .rsv_dirty (hdr_rsv)
    );

    // flush request holder
    sbpcd_flush_ctl u_flush (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .start       (flush_go),
        .flush_done  (flush_done),
        .flush_req_q (flush_req_q),
        .done_q      (flush_fin)
    );

    // next state of the decoder
    always @* begin
        state_d = state_q;
        idx_d   = idx_q;
        len_d   = len_q;
        case (state_q)
            ST_IDLE, ST_SKIP: begin
                if (take && cmd_first) begin
                    idx_d = 9'h001;
                    len_d = hdr_len;
                    if (ctrl_en_q && hdr_hit) begin
                        // a header-only command still flushes
                        state_d = (hdr_len > 9'h001) ? ST_BODY : ST_FLUSH;
                    end else begin
                        state_d = ST_SKIP;
                    end
                end
            end
            ST_BODY: begin
                if (take && cmd_first) begin
                    // a new header cuts this command; it is abandoned
                    state_d = ST_IDLE;
                end else if (take) begin
                    idx_d = idx_q + 9'h001;
                    if (idx_q + 9'h001 >= len_q) begin
                        state_d = ST_FLUSH;
                    end
                end
            end
            ST_FLUSH: begin
                state_d = ST_WAIT;
            end
            ST_WAIT: begin
                if (flush_fin) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // decoder registers and ready
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q     <= ST_IDLE;
            idx_q       <= 9'h000;
            len_q       <= 9'h000;
            cmd_ready_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            idx_q       <= idx_d;
            len_q       <= len_d;
            // stall the streamer while a flush is outstanding
            cmd_ready_q <= (state_d == ST_IDLE) || (state_d == ST_BODY) || (state_d == ST_SKIP);
        end
    end

    // staging of address dwords; only applied after the flush
    always @(posedge aclk) begin
        if (!aresetn) begin
            gen_pend_q  <= 20'h00000;
            surf_pend_q <= 20'h00000;
            ind_pend_q  <= 20'h00000;
            pend_en_q   <= 3'h0;
        end else if (take && cmd_first) begin
            pend_en_q <= 3'h0; // new command starts with nothing staged
        end else if (take && state_q == ST_BODY) begin
            case (idx_q)
                `SBPCD_DW_GEN: begin
                    gen_pend_q   <= cmd_data[`SBPCD_BASE_HI:`SBPCD_BASE_LO];
                    pend_en_q[0] <= mod_en;
                end
                `SBPCD_DW_SURF: begin
                    surf_pend_q  <= cmd_data[`SBPCD_BASE_HI:`SBPCD_BASE_LO];
                    pend_en_q[1] <= mod_en;
                end
                `SBPCD_DW_IND: begin
                    ind_pend_q   <= cmd_data[`SBPCD_BASE_HI:`SBPCD_BASE_LO];
                    pend_en_q[2] <= mod_en;
                end
                default: begin
                    // bound dwords and beyond are consumed and ignored
                end
            endcase
        end
    end

    // live bases: change only after the drain, only when enabled
    always @(posedge aclk) begin
        if (!aresetn) begin
            gen_base_q  <= 20'h00000;
            surf_base_q <= 20'h00000;
            ind_base_q  <= 20'h00000;
            apply_q     <= 1'b0;
            cmd_count_q <= 32'h00000000;
        end else begin
            apply_q <= 1'b0;
            if (state_q == ST_WAIT && flush_fin) begin
                // a zero base leaves offsets absolute downstream
                if (pend_en_q[0]) gen_base_q  <= gen_pend_q;
                if (pend_en_q[1]) surf_base_q <= surf_pend_q;
                if (pend_en_q[2]) ind_base_q  <= ind_pend_q;
                apply_q     <= 1'b1;
                cmd_count_q <= cmd_count_q + 32'h00000001;
            end
        end
    end

    // write channel: capture both halves in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_awready <= 1'b1;
            s_wready  <= 1'b1;
            s_bvalid  <= 1'b0;
            s_bresp   <= `SBPCD_RESP_OKAY;
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h00000000;
            w_strb_q  <= 4'h0;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_addr_q <= s_awaddr;
                aw_held_q <= 1'b1;
                s_awready <= 1'b0;
            end
            if (s_wvalid && s_wready) begin
                w_data_q <= s_wdata;
                w_strb_q <= s_wstrb;
                w_held_q <= 1'b1;
                s_wready <= 1'b0;
            end
            // both halves held: answer
            if (aw_held_q && w_held_q && !s_bvalid) begin
                s_bvalid  <= 1'b1;
                s_bresp   <= mapped(aw_addr_q) ? `SBPCD_RESP_OKAY : `SBPCD_RESP_DECERR;
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
            end

            // response taken: reopen both channels
            if (s_bvalid && s_bready) begin
                s_bvalid  <= 1'b0;
                s_awready <= 1'b1;
                s_wready  <= 1'b1;
            end
        end
    end

    // register write effects and sticky flags
    wire wr_fire = aw_held_q && w_held_q && !s_bvalid && w_strb_q[0];
    wire rsv_set = take && ((cmd_first && hdr_hit && hdr_rsv) ||
                            (state_q == ST_BODY && !cmd_first && idx_q <= `SBPCD_DW_IND && addr_rsv));
    wire trunc_set = take && cmd_first && state_q == ST_BODY;
    wire st_clr = wr_fire && aw_addr_q == `SBPCD_REG_STATUS;

    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_en_q    <= `SBPCD_CTRL_RESET;
            rsv_flag_q   <= 1'b0;
            trunc_flag_q <= 1'b0;
        end else begin
            if (wr_fire && aw_addr_q == `SBPCD_REG_CTRL) begin
                ctrl_en_q <= w_data_q[`SBPCD_CTRL_EN_BIT];
            end

            // a new event wins over a write-one clear
            if (rsv_set) begin
                rsv_flag_q <= 1'b1;
            end else if (st_clr && w_data_q[`SBPCD_ST_RSV_BIT]) begin
                rsv_flag_q <= 1'b0;
            end
            if (trunc_set) begin
                trunc_flag_q <= 1'b1;
            end else if (st_clr && w_data_q[`SBPCD_ST_TRUNC_BIT]) begin
                trunc_flag_q <= 1'b0;
            end
        end
    end

    // status word assembled from live state
    wire [31:0] status_w = {28'h0000000, trunc_flag_q, rsv_flag_q, flush_req_q,
                            (state_q != ST_IDLE && state_q != ST_SKIP)};

    // read channel: one read at a time, data from a register
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b1;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h00000000;
            s_rresp   <= `SBPCD_RESP_OKAY;
        end else begin
            if (s_arvalid && s_arready) begin
                s_arready <= 1'b0;
                s_rvalid  <= 1'b1;
                s_rresp   <= mapped(s_araddr) ? `SBPCD_RESP_OKAY : `SBPCD_RESP_DECERR;
                case (s_araddr)
                    `SBPCD_REG_CTRL:      s_rdata <= {31'h00000000, ctrl_en_q};
                    `SBPCD_REG_STATUS:    s_rdata <= status_w;
                    `SBPCD_REG_GEN_BASE:  s_rdata <= {gen_base_q, 12'h000};
                    `SBPCD_REG_SURF_BASE: s_rdata <= {surf_base_q, 12'h000};
                    `SBPCD_REG_IND_BASE:  s_rdata <= {ind_base_q, 12'h000};
                    `SBPCD_REG_CMD_COUNT: s_rdata <= cmd_count_q;
                    default:              s_rdata <= 32'h00000000;
                endcase
            end else if (s_rvalid && s_rready) begin
                s_rvalid  <= 1'b0;
                s_arready <= 1'b1;
            end
        end
    end
endmodule // sbpcd_top

// ==== sbpcd_props.sv ====
// Purpose: temporal checks on the base pointer decoder ports
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound into every sbpcd_top instance
`timescale 1ns/100ps

module sbpcd_props (
    input wire        aclk,        // engine clock
    input wire        aresetn,     // sync reset, active low
    input wire        cmd_ready_q, // decoder takes dword
    input wire        flush_req_q, // flush request level
    input wire        flush_done,  // pipe drained pulse
    input wire [19:0] gen_base_q,  // general state base
    input wire [19:0] surf_base_q, // surface state base
    input wire [19:0] ind_base_q,  // indirect object base
    input wire        apply_q      // new bases in effect
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // reset must clear the bases, cmd_ready_q, flush_req_q and apply_q
    property p_rst;
        disable iff (1'b0) !aresetn |=> !cmd_ready_q && !flush_req_q && !apply_q
            && (gen_base_q | surf_base_q | ind_base_q) == 20'h00000;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    // a base may move only in the apply cycle
    property p_gen;
        $changed(gen_base_q) |-> apply_q;
    endproperty
    a_gen: assert property (p_gen) else $error("general base moved outside apply");
    property p_surf;
        $changed(surf_base_q) |-> apply_q;
    endproperty
    a_surf: assert property (p_surf) else $error("surface base moved outside apply");
    property p_ind;
        $changed(ind_base_q) |-> apply_q;
    endproperty
    a_ind: assert property (p_ind) else $error("indirect base moved outside apply");
    property p_pulse;
        apply_q |=> !apply_q;
    endproperty
    a_pulse: assert property (p_pulse) else $error("apply longer than one cycle");
    // request stands until the pipe reports drained
    property p_hold;
        flush_req_q && !flush_done |=> flush_req_q;
    endproperty
    a_hold: assert property (p_hold) else $error("flush request dropped early");
    property p_fin;
        flush_req_q && flush_done |-> ##[1:3] apply_q;
    endproperty
    a_fin: assert property (p_fin) else $error("no apply after flush finished");
    // no new dwords while the pipe drains
    property p_stall;
        flush_req_q |-> !cmd_ready_q;
    endproperty
    a_stall: assert property (p_stall) else $error("dword taken during flush");
    property p_src;
        $rose(apply_q) |-> $past(flush_done, 1) || $past(flush_done, 2);
    endproperty
    a_src: assert property (p_src) else $error("apply without a finished flush");
endmodule // sbpcd_props

bind sbpcd_top sbpcd_props u_props (.*);

// ==== sbpcd_stream_model.sv ====
// Purpose: command streamer and pipeline drain model
// Assumes: dwords queued by the bench through push
// Notes: slow sets the drain latency in cycles
`timescale 1ns/100ps

module sbpcd_stream_model (
    input  wire        aclk,        // engine clock
    input  wire        aresetn,     // sync reset, active low
    input  wire        cmd_ready_q, // decoder takes dword
    input  wire        flush_req_q, // flush requested
    output reg         cmd_valid,   // dword offered
    output reg  [31:0] cmd_data,    // command dword
    output reg         cmd_first,   // dword is a header
    output reg         flush_done   // pulse: pipe drained
);
    logic [32:0] q[$];   // pending {first, data}
    int          slow;   // drain latency
    int          wait_n; // cycles in current flush
    bit          sent;   // drained pulse given
    initial {cmd_valid, cmd_data, cmd_first, flush_done, slow} = 0;
    task push(input [31:0] d, input f);
        q.push_back({f, d});
    endtask
    // offer head of queue, hold it until taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            cmd_valid <= 1'b0;
        end else begin
            if (cmd_valid && cmd_ready_q) void'(q.pop_front());
            if (q.size() > 0) begin
                cmd_valid              <= 1'b1;
                {cmd_first, cmd_data}  <= q[0];
            end else begin
                // idle data keeps toggling so stale words never look valid
                cmd_valid <= 1'b0;
                cmd_first <= 1'b0;
                cmd_data  <= ~cmd_data;
            end
        end
    end
    // one drained pulse per request, only while it is up
    always @(posedge aclk) begin
        if (!aresetn || !flush_req_q) begin
            flush_done <= 1'b0;
            wait_n     <= 0;
            sent       <= 1'b0;
        end else begin
            wait_n     <= wait_n + 1;
            flush_done <= !sent && wait_n >= slow;
            if (!sent && wait_n >= slow) sent <= 1'b1;
        end
    end
endmodule // sbpcd_stream_model

// ==== state_base_pointer_command_decoder_tb_top.sv ====
// Purpose: self-checking bench for the base pointer decoder
// Assumes: streamer model on the command side, AXI4-Lite master tasks
// Notes: no-effect cases are judged after the queue drains plus a margin
`timescale 1ns/100ps

module state_base_pointer_command_decoder_tb_top;
    localparam [31:0] hdr_ok = 32'h61010004; // base pointer header, length 4
    reg         aclk;
    reg         aresetn;
    reg  [7:0]  s_awaddr, s_araddr;
    reg  [31:0] s_wdata;
    reg         s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
    wire        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    wire [1:0]  s_bresp, s_rresp;
    wire [31:0] s_rdata, cmd_data;
    wire        cmd_valid, cmd_first, cmd_ready_q, flush_req_q, flush_done, apply_q;
    wire [19:0] gen_base_q, surf_base_q, ind_base_q;
    int         n_fail, samples_checked, n_apply, na, k, n;
    logic [31:0] rv;     // last read data
    logic [1:0]  rr;     // last response
    logic [31:0] bad[4]; // header spoil masks
    sbpcd_top uut (.*, .s_wstrb(4'hF));
    sbpcd_stream_model u_strm (.*);
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    // count apply pulses seen at the ports
    always @(posedge aclk) if (apply_q === 1'b1) n_apply <= n_apply + 1;
    task test_done;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task hang;
        n_fail++;
        $display("[FAIL] wait exp done got timeout");
        test_done();
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task axw(input [7:0] a, input [31:0] d);
        @(posedge aclk);
        s_awaddr  <= a;
        s_wdata   <= d;
        s_awvalid <= 1'b1;
        s_wvalid  <= 1'b1;
        s_bready  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
            if (s_bvalid) break;
        end
        rr = s_bresp;
        s_bready <= 1'b0;
        if (n == 100) hang();
    endtask
    task axr(input [7:0] a);
        @(posedge aclk);
        s_araddr  <= a;
        s_arvalid <= 1'b1;
        s_rready  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_arready) s_arvalid <= 1'b0;
            if (s_rvalid) break;
        end
        rv = s_rdata;
        rr = s_rresp;
        s_rready <= 1'b0;
        if (n == 100) hang();
    endtask
    task rdc(input [7:0] a, input [31:0] e);
        axr(a);
        chk($sformatf("reg %h", a), e, rv);
        chk("rresp", 32'h0, rr);
    endtask
    // header, three address dwords, two trailing zero dwords
    task cmd(input [31:0] h, input [31:0] g, input [31:0] s, input [31:0] i);
        u_strm.push(h, 1'b1);
        u_strm.push(g, 1'b0);
        u_strm.push(s, 1'b0);
        u_strm.push(i, 1'b0);
        u_strm.push(32'h0, 1'b0);
        u_strm.push(32'h0, 1'b0);
    endtask
    task wait_apply(input int t);
        for (n = 0; n < 600 && n_apply < t; n++) @(posedge aclk);
        if (n_apply < t) hang();
    endtask
    // queue drained, then margin for a wrongly started flush
    task idle;
        for (n = 0; n < 600 && u_strm.q.size() > 0; n++) @(posedge aclk);
        if (n == 600) hang();
        repeat (40) @(posedge aclk);
    endtask
    task bases(input [19:0] g, input [19:0] s, input [19:0] i);
        chk("gen_base_q", g, gen_base_q);
        chk("surf_base_q", s, surf_base_q);
        chk("ind_base_q", i, ind_base_q);
    endtask
    initial begin
        {n_fail, samples_checked, n_apply, s_awaddr, s_araddr, s_wdata} = 0;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 0;
        bad = '{32'h20000000, 32'h08000000, 32'h03000000, 32'h00020000};
        aresetn = 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(8'h00, 32'h1);
        for (k = 1; k < 6; k++) rdc(k * 4, 32'h0);
        axr(8'h18);
        chk("unmapped rresp", 32'h3, rr);
        axw(8'h18, 32'hFFFFFFFF);
        chk("unmapped bresp", 32'h3, rr);
        $display("test reset done");
        cmd(hdr_ok, 32'h12345001, 32'hABCDE001, 32'h00F00001);
        wait_apply(1);
        bases(20'h12345, 20'hABCDE, 20'h00F00);
        rdc(8'h08, 32'h12345000);
        rdc(8'h0C, 32'hABCDE000);
        rdc(8'h10, 32'h00F00000);
        $display("test load done");
        // back to back, mixed enables, longer command with extra dwords
        cmd(hdr_ok, 32'h55555000, 32'h00001001, 32'h77777000);
        cmd(hdr_ok + 32'h2, 32'h66666000, 32'h88888000, 32'h00000001);
        u_strm.push(hdr_ok, 1'b0);
        u_strm.push(32'h99999001, 1'b0);
        wait_apply(3);
        bases(20'h12345, 20'h00001, 20'h00000);
        rdc(8'h14, 32'h3);
        $display("test enable done");
        na = n_apply;
        for (k = 0; k < 4; k++) cmd(hdr_ok ^ bad[k], 32'hFFFFF001, 32'hFFFFF001, 32'hFFFFF001);
        idle();
        chk("applies", na, n_apply);
        bases(20'h12345, 20'h00001, 20'h00000);
        $display("test foreign done");
        // issuer breaks the zero rule on purpose to raise the dirty flag
        cmd(hdr_ok | 32'h00000100, 32'h12345001, 32'h00001001, 32'h00000001);
        idle();
        rdc(8'h04, 32'h4);
        axw(8'h04, 32'h4);
        rdc(8'h04, 32'h0);
        $display("test reserved done");
        na = n_apply;
        u_strm.push(hdr_ok, 1'b1);
        u_strm.push(32'h99999001, 1'b0);
        cmd(hdr_ok, 32'h99999001, 32'h99999001, 32'h99999001);
        idle();
        chk("applies", na, n_apply);
        rdc(8'h04, 32'h8);
        axw(8'h04, 32'h8);
        bases(20'h12345, 20'h00001, 20'h00000);
        $display("test truncate done");
        axw(8'h00, 32'h0);
        rdc(8'h00, 32'h0);
        cmd(hdr_ok, 32'hAAAAA001, 32'hAAAAA001, 32'hAAAAA001);
        idle();
        chk("applies", na, n_apply);
        axw(8'h00, 32'h1);
        $display("test disable done");
        u_strm.slow = 40;
        cmd(hdr_ok, 32'h00000001, 32'h00000001, 32'h00000001);
        for (k = 0; k < 200 && flush_req_q !== 1'b1; k++) @(posedge aclk);
        if (k == 200) hang();
        rdc(8'h04, 32'h3);
        bases(20'h12345, 20'h00001, 20'h00000);
        wait_apply(na + 1);
        bases(20'h00000, 20'h00000, 20'h00000);
        $display("test flush done");
        test_done();
    end
endmodule // state_base_pointer_command_decoder_tb_top
